// ===== rtl/id_event_defs.svh
// Offsets, field positions, reset values and timing counts for the ID event block.
`ifndef ID_EVENT_DEFS_SVH
`define ID_EVENT_DEFS_SVH

`define ADDR_EN_WRITE 8'h1D
`define ADDR_EN_SET 8'h1E
`define ADDR_EN_CLEAR 8'h1F
`define ADDR_STATUS 8'h20
`define ADDR_LATCH 8'h21
`define ADDR_VEND_WRITE 8'h36
`define ADDR_VEND_SET 8'h37
`define ADDR_VEND_CLEAR 8'h38
`define ADDR_IMMEDIATE_MASK 8'h3F

`define EN_RISE_BIT 0
`define EN_FALL_BIT 1
`define EN_MEAS_BIT 5
`define EN_WRITABLE 8'h23
`define EN_RESET 8'h00

`define ST_FLOAT_BIT 0
`define ST_CODE_LSB 3
`define ST_DONE_BIT 6

`define LAT_FLOAT_BIT 0
`define LAT_MEAS_BIT 3

`define VEND_CODE_LSB 0
`define VEND_DONE_BIT 3
`define VEND_GO_BIT 4
`define VEND_RSVD_BIT 5
`define VEND_IRQ_BIT 6
`define VEND_WRITABLE 8'h70
`define VEND_RESET 8'h00

`define CODE_RESET 3'h0

`define MEASURE_TIME_NS 282000
`define CLOCK_PERIOD_PS 5000
`define MEASURE_CYCLES ((`MEASURE_TIME_NS * 1000) / `CLOCK_PERIOD_PS)
`define MEASURE_CNT_W 17

`endif

// ===== rtl/id_event_pkg.sv
// Types shared by the ID event block and its register access port.
package id_event_pkg;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic ext;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed
   {
      logic valid;
      logic [7:0] data;
   } reg_resp_t;

   typedef enum logic [1:0]
   {
      MEAS_IDLE = 2'b01,
      MEAS_BUSY = 2'b10
   } meas_state_t;

endpackage

// ===== rtl/id_resistor_event_irq.sv
// ID pin float and resistance measurement events with enable, status and latch registers.
`timescale 1ns/1ps
`include "id_event_defs.svh"

module id_resistor_event_irq
#(
   parameter int MEASURE_CYCLES = `MEASURE_CYCLES
)
(
   input wire logic clock,
   input wire logic rst,
   input wire id_event_pkg::reg_req_t reg_req,
   output id_event_pkg::reg_resp_t reg_resp,
   input wire logic open_pin_raw,
   input wire logic [2:0] conv_code,
   output logic measure_busy,
   output logic alt_int
);
   import id_event_pkg::*;

   // Immediate accesses carry six address bits; extended ones carry eight.
   function automatic logic [7:0] eff_addr(input logic ext, input logic [7:0] addr);
      eff_addr = ext ? addr : (addr & `ADDR_IMMEDIATE_MASK);
   endfunction

   // Write, set or clear on a three-address register, limited to its writable bits.
   function automatic logic [7:0] wsc(input logic [7:0] cur, input logic [7:0] data,
                                      input logic [1:0] op, input logic [7:0] mask);
      logic [7:0] res;
      res = cur;
      if (op == 2'd0)
      begin
         res = data;
      end
      else if (op == 2'd1)
      begin
         res = cur | data;
      end
      else
      begin
         res = cur & ~data;
      end
      wsc = (res & mask) | (cur & ~mask);
   endfunction

   logic s1_r, s2_r, s3_r, float_r, float_nxt;
   logic [7:0] en_r, en_nxt, vend_r, vend_nxt;
   logic [2:0] code_r, code_nxt;
   logic done_r, done_nxt;
   logic lat_float_r, lat_float_nxt, lat_meas_r, lat_meas_nxt;
   meas_state_t state_r, state_nxt;
   logic [`MEASURE_CNT_W-1:0] cnt_r, cnt_nxt;
   reg_resp_t resp_r, resp_nxt;

   logic [7:0] addr;
   logic wr_en, set_en, clr_en, wr_vend, set_vend, clr_vend;
   logic rd_vend, rd_latch, finish, meas_irq_en, float_rise, float_fall;
   logic [7:0] rd_en, rd_status, rd_latch_val, rd_vendor;

   always_comb
   begin
      addr = eff_addr(reg_req.ext, reg_req.addr);
      // Only the three aliased addresses touch the enable register.
      wr_en = reg_req.wr && (addr == `ADDR_EN_WRITE);
      set_en = reg_req.wr && (addr == `ADDR_EN_SET);
      clr_en = reg_req.wr && (addr == `ADDR_EN_CLEAR);
      wr_vend = reg_req.wr && (addr == `ADDR_VEND_WRITE);
      set_vend = reg_req.wr && (addr == `ADDR_VEND_SET);
      clr_vend = reg_req.wr && (addr == `ADDR_VEND_CLEAR);
      rd_vend = reg_req.rd && (addr >= `ADDR_VEND_WRITE) && (addr <= `ADDR_VEND_CLEAR);
      rd_latch = reg_req.rd && (addr == `ADDR_LATCH);
      float_rise = float_nxt && !float_r;
      float_fall = !float_nxt && float_r;
      meas_irq_en = en_r[`EN_MEAS_BIT] || vend_r[`VEND_IRQ_BIT];
      finish = (state_r == MEAS_BUSY) && (cnt_r == '0);
   end

   // A pin change is taken only once the second and third stages agree.
   always_comb
   begin
      float_nxt = (s2_r == s3_r) ? s3_r : float_r;
   end

   always_comb
   begin
      en_nxt = en_r;
      if (wr_en)
      begin
         en_nxt = wsc(en_r, reg_req.wdata, 2'd0, `EN_WRITABLE);
      end
      else if (set_en)
      begin
         en_nxt = wsc(en_r, reg_req.wdata, 2'd1, `EN_WRITABLE);
      end
      else if (clr_en)
      begin
         en_nxt = wsc(en_r, reg_req.wdata, 2'd2, `EN_WRITABLE);
      end
   end

   always_comb
   begin
      vend_nxt = vend_r;
      if (wr_vend)
      begin
         vend_nxt = wsc(vend_r, reg_req.wdata, 2'd0, `VEND_WRITABLE);
      end
      else if (set_vend)
      begin
         vend_nxt = wsc(vend_r, reg_req.wdata, 2'd1, `VEND_WRITABLE);
      end
      else if (clr_vend)
      begin
         vend_nxt = wsc(vend_r, reg_req.wdata, 2'd2, `VEND_WRITABLE);
      end
      // Completion wins over a same-cycle write so the start bit cannot stick.
      if (finish)
      begin
         vend_nxt[`VEND_GO_BIT] = 1'b0;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      code_nxt = code_r;
      case (state_r)
         MEAS_IDLE:
         begin
            if (vend_nxt[`VEND_GO_BIT] && !vend_r[`VEND_GO_BIT])
            begin
               state_nxt = MEAS_BUSY;
               cnt_nxt = `MEASURE_CNT_W'(MEASURE_CYCLES - 1);
            end
         end
         MEAS_BUSY:
         begin
            if (finish)
            begin
               state_nxt = MEAS_IDLE;
               code_nxt = conv_code;
            end
            else
            begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default:
         begin
            state_nxt = MEAS_IDLE;
         end
      endcase
   end

   always_comb
   begin
      // Set wins over a read clear so a finish in the read cycle is not lost.
      done_nxt = finish ? 1'b1 : (rd_vend ? 1'b0 : done_r);
      lat_float_nxt = lat_float_r && !rd_latch;
      if ((float_rise && en_r[`EN_RISE_BIT]) || (float_fall && en_r[`EN_FALL_BIT]))
      begin
         lat_float_nxt = 1'b1;
      end
      lat_meas_nxt = lat_meas_r && !rd_latch;
      if (done_nxt && !done_r && meas_irq_en)
      begin
         lat_meas_nxt = 1'b1;
      end
   end

   always_comb
   begin
      rd_en = en_r & `EN_WRITABLE;
      rd_status = '0;
      rd_status[`ST_FLOAT_BIT] = float_r;
      rd_status[`ST_CODE_LSB +: 3] = code_r;
      rd_status[`ST_DONE_BIT] = done_r;
      rd_latch_val = '0;
      rd_latch_val[`LAT_FLOAT_BIT] = lat_float_r;
      rd_latch_val[`LAT_MEAS_BIT] = lat_meas_r;
      rd_vendor = vend_r & `VEND_WRITABLE;
      rd_vendor[`VEND_CODE_LSB +: 3] = code_r;
      rd_vendor[`VEND_DONE_BIT] = done_r;
      resp_nxt.valid = reg_req.rd;
      resp_nxt.data = '0;
      if (!reg_req.rd)
      begin
         resp_nxt.data = '0;
      end
      else if ((addr >= `ADDR_EN_WRITE) && (addr <= `ADDR_EN_CLEAR))
      begin
         resp_nxt.data = rd_en;
      end
      else if (addr == `ADDR_STATUS)
      begin
         resp_nxt.data = rd_status;
      end
      else if (addr == `ADDR_LATCH)
      begin
         resp_nxt.data = rd_latch_val;
      end
      else if (rd_vend)
      begin
         resp_nxt.data = rd_vendor;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         float_r <= 1'b0;
         en_r <= `EN_RESET;
         vend_r <= `VEND_RESET;
         code_r <= `CODE_RESET;
         done_r <= 1'b0;
         lat_float_r <= 1'b0;
         lat_meas_r <= 1'b0;
         state_r <= MEAS_IDLE;
         cnt_r <= '0;
         resp_r <= '0;
      end
      else
      begin
         s1_r <= open_pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         float_r <= float_nxt;
         en_r <= en_nxt;
         vend_r <= vend_nxt;
         code_r <= code_nxt;
         done_r <= done_nxt;
         lat_float_r <= lat_float_nxt;
         lat_meas_r <= lat_meas_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         resp_r <= resp_nxt;
      end
   end

   assign reg_resp = resp_r;
   assign measure_busy = (state_r == MEAS_BUSY);
   // The level drops in the cycle after the latch read, so one event is reported once.
   assign alt_int = lat_float_r || lat_meas_r;

endmodule

// ===== tb/id_pin_model.sv
// Model of the ID pin sense and the resistance converter.
`timescale 1ns/1ps
module id_pin_model
(
   input wire logic float_set,
   input wire logic [2:0] code_set,
   input wire logic measure_busy,
   output wire logic open_pin_raw,
   output wire logic [2:0] conv_code
);
   // The pin moves off the edge, so the synchroniser gets real work.
   assign #2 open_pin_raw = float_set;
   // Outside a run the result lines carry junk, so a late sample shows.
   assign conv_code = measure_busy ? code_set : ~code_set;
endmodule

// ===== tb/id_event_checker.sv
// Port assertions for the ID event block.
`timescale 1ns/1ps
module id_event_checker
#(parameter int MEASURE_CYCLES = 8)
(
   input wire logic clock,
   input wire logic rst,
   input wire id_event_pkg::reg_req_t reg_req,
   input wire id_event_pkg::reg_resp_t reg_resp,
   input wire logic open_pin_raw,
   input wire logic [2:0] conv_code,
   input wire logic measure_busy,
   input wire logic alt_int
);
   import id_event_pkg::*;
   logic [7:0] a;
   logic rl;
   logic [16:0] cnt_r;
   assign a = reg_req.ext ? reg_req.addr : {2'h0, reg_req.addr[5:0]};
   assign rl = reg_req.rd && a == 8'h21;
   logic prev_r;
   logic [2:0] stab_r;
   always_ff @(posedge clock or posedge rst)
      if (rst)
         cnt_r <= '0;
      else
         cnt_r <= measure_busy ? cnt_r + 17'h1 : 17'h0;
   // Counts quiet cycles on the raw pin, so the float check waits out the synchroniser.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prev_r <= 1'b0;
         stab_r <= 3'h0;
      end
      else
      begin
         prev_r <= open_pin_raw;
         stab_r <= (open_pin_raw != prev_r) ? 3'h0 : ((stab_r == 3'h7) ? stab_r : stab_r + 3'h1);
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_ans; reg_req.rd |=> reg_resp.valid; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_idle; !reg_req.rd |=> reg_resp == '0; endproperty
   a_idle: assert property (p_idle) else $error("stray data");
   property p_en; reg_req.rd && a >= 8'h1D && a <= 8'h1F |=> (reg_resp.data & 8'hDC) == 8'h00;
   endproperty
   a_en: assert property (p_en) else $error("enable bits");
   property p_st; reg_req.rd && a == 8'h20 |=> reg_resp.data[7] == 1'h0
      && reg_resp.data[2:1] == 2'h0; endproperty
   a_st: assert property (p_st) else $error("status bits");
   property p_flt; reg_req.rd && a == 8'h20 && stab_r >= 3'h4
      |=> reg_resp.data[0] == $past(open_pin_raw); endproperty
   a_flt: assert property (p_flt) else $error("float status");
   property p_lat; rl |=> (reg_resp.data & 8'hF6) == 8'h00; endproperty
   a_lat: assert property (p_lat) else $error("latch bits");
   property p_int; rl |=> (reg_resp.data != 8'h00) == $past(alt_int); endproperty
   a_int: assert property (p_int) else $error("alt_int");
   property p_len; $fell(measure_busy) |-> cnt_r == MEASURE_CYCLES; endproperty
   a_len: assert property (p_len) else $error("run length");
   property p_go; reg_req.wr && (a == 8'h36 || a == 8'h37) && reg_req.wdata[4]
      && !measure_busy |=> measure_busy; endproperty
   a_go: assert property (p_go) else $error("no start");
   c_lat: cover property (rl ##1 reg_resp.data[3]);
   c_end: cover property ($fell(measure_busy));
   c_int: cover property ($rose(alt_int));
endmodule
bind id_resistor_event_irq id_event_checker #(.MEASURE_CYCLES(MEASURE_CYCLES)) i_id_event_checker
   (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_resp(reg_resp),
   .open_pin_raw(open_pin_raw), .conv_code(conv_code), .measure_busy(measure_busy),
   .alt_int(alt_int));

// ===== tb/tb.sv
// Self-checking bench for the ID event block.
`timescale 1ns/1ps
module tb;
   import id_event_pkg::*;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic flt = 1'h0;
   logic [2:0] code = 3'h5;
   reg_req_t reg_req = '0;
   reg_resp_t reg_resp;
   logic open_pin_raw, measure_busy, alt_int;
   logic [2:0] conv_code;
   int failures = 0;
   int tests_run = 0;
   always #2.5 clock = ~clock;
   id_resistor_event_irq #(.MEASURE_CYCLES(8)) i_id_resistor_event_irq (.clock(clock),
      .rst(rst), .reg_req(reg_req), .reg_resp(reg_resp), .open_pin_raw(open_pin_raw),
      .conv_code(conv_code), .measure_busy(measure_busy), .alt_int(alt_int));
   id_pin_model i_id_pin_model (.float_set(flt), .code_set(code),
      .measure_busy(measure_busy), .open_pin_raw(open_pin_raw), .conv_code(conv_code));
   task end_sim;
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] ad, input logic [7:0] d, input logic x);
      @(posedge clock);
      reg_req <= {1'h1, 1'h0, x, ad, d};
      @(posedge clock);
      reg_req <= '0;
   endtask
   task rd(input logic [7:0] ad, input logic x, input logic [7:0] e);
      @(posedge clock);
      reg_req <= {1'h0, 1'h1, x, ad, 8'h00};
      @(posedge clock);
      reg_req <= '0;
      #1;
      chk(reg_resp.data, e);
   endtask
   // The pin passes a synchroniser and filter, so allow it time to land.
   task pin(input logic v);
      @(posedge clock);
      flt <= v;
      repeat (8) @(posedge clock);
      #1;
   endtask
   // A new code per run shows whether the result is taken while the converter holds it.
   task meas(input logic [7:0] ad, input logic [7:0] d, input logic [2:0] c);
      @(posedge clock);
      code <= c;
      wr(ad, d, 1'h1);
      for (int i = 0; i <= 40; i++)
      begin
         @(posedge clock);
         #1;
         if (measure_busy === 1'h0)
            break;
         if (i == 40)
         begin
            failures++;
            end_sim();
         end
      end
   endtask
   initial
   begin
      repeat (4) @(posedge clock);
      rst <= 1'h0;
      rd(8'h1D, 1'h1, 8'h00);
      rd(8'h21, 1'h1, 8'h00);
      wr(8'h1D, 8'hFF, 1'h1);
      rd(8'h1D, 1'h1, 8'h23);
      wr(8'h1F, 8'h21, 1'h1);
      rd(8'h1E, 1'h1, 8'h02);
      wr(8'h5E, 8'h01, 1'h0);
      rd(8'h1F, 1'h1, 8'h03);
      rd(8'h5D, 1'h0, 8'h03);
      pin(1'h1);
      chk({7'h00, alt_int}, 8'h01);
      wr(8'h20, 8'hFF, 1'h1);
      rd(8'h20, 1'h1, 8'h01);
      rd(8'h21, 1'h1, 8'h01);
      rd(8'h21, 1'h1, 8'h00);
      chk({7'h00, alt_int}, 8'h00);
      pin(1'h0);
      chk({7'h00, alt_int}, 8'h01);
      rd(8'h21, 1'h1, 8'h01);
      wr(8'h1F, 8'h01, 1'h1);
      pin(1'h1);
      rd(8'h21, 1'h1, 8'h00);
      wr(8'h1D, 8'h20, 1'h1);
      meas(8'h36, 8'h10, 3'h5);
      rd(8'h20, 1'h1, 8'h69);
      rd(8'h20, 1'h1, 8'h69);
      chk({7'h00, alt_int}, 8'h01);
      rd(8'h21, 1'h1, 8'h08);
      rd(8'h36, 1'h1, 8'h0D);
      rd(8'h20, 1'h1, 8'h29);
      wr(8'h1D, 8'h00, 1'h1);
      meas(8'h37, 8'h50, 3'h3);
      rd(8'h21, 1'h1, 8'h08);
      rd(8'h20, 1'h1, 8'h59);
      rd(8'h38, 1'h1, 8'h4B);
      rd(8'h78, 1'h0, 8'h43);
      // A second reset after the second run, with the pin still floating and the vendor interrupt bit still set.
      @(posedge clock);
      rst <= 1'h1;
      repeat (2) @(posedge clock);
      rst <= 1'h0;
      rd(8'h38, 1'h1, 8'h00);
      rd(8'h1D, 1'h1, 8'h00);
      rd(8'h20, 1'h1, 8'h01);
      rd(8'h21, 1'h1, 8'h00);
      chk({7'h00, alt_int}, 8'h00);
      end_sim();
   end
endmodule
